//--- hw/cbfsl_pkg.sv
package cbfsl_pkg;
  // opcode bytes
  localparam logic [7:0] OP_TWO_BYTE = 8'h0f;
  localparam logic [7:0] OP_BRANCH_PARITY_ODD_S = 8'h7b;
  localparam logic [7:0] OP_BRANCH_ON_NEGATIVE_S = 8'h78;
  localparam logic [7:0] OP_BRANCH_ON_ZERO_S = 8'h74;
  localparam logic [7:0] OP_BRANCH_PARITY_ODD_N = 8'h8b;
  localparam logic [7:0] OP_BRANCH_ON_NEGATIVE_N = 8'h88;
  localparam logic [7:0] OP_BRANCH_ON_ZERO_N = 8'h84;
  localparam logic [7:0] OP_FLAGS_TO_HIGH_ACC = 8'h9f;
  localparam logic [7:0] OP_ACCESS_RIGHTS_LOAD = 8'h02;
  localparam logic [7:0] OP_FAR_POINTER_DATA_SEG_LOAD = 8'hc5;
  // condition nibble of the branch opcodes
  localparam logic [3:0] CC_PARITY_ODD = 4'hb;
  localparam logic [3:0] CC_NEGATIVE = 4'h8;
  localparam logic [3:0] CC_ZERO = 4'h4;
  // exception vectors
  localparam logic [7:0] VEC_UD = 8'h06;
  localparam logic [7:0] VEC_NP = 8'h0b;
  localparam logic [7:0] VEC_SS = 8'h0c;
  localparam logic [7:0] VEC_GP = 8'h0d;
  localparam logic [7:0] VEC_PF = 8'h0e;
  localparam logic [7:0] VEC_AC = 8'h11;
  // clocks per instruction
  localparam logic [3:0] CLK_BR_TRUE = 4'h3;
  localparam logic [3:0] CLK_BR_FALSE = 4'h1;
  localparam logic [3:0] CLK_FLAGS_TO_HIGH_ACC = 4'h3;
  localparam logic [3:0] CLK_ACCESS_RIGHTS = 4'hb;
  localparam logic [3:0] CLK_LDS_REAL = 4'h6;
  localparam logic [3:0] CLK_LDS_PROT = 4'hc;
  // masks, offsets, sizes
  localparam logic [31:0] IP16_MASK = 32'h0000ffff;
  localparam logic [31:0] LAR_MASK = 32'h00ffff00;
  localparam logic [15:0] LAR_SYS_VALID = 16'hdafe;
  localparam logic [31:0] SEL_OFS16 = 32'h00000002;
  localparam logic [31:0] SEL_OFS32 = 32'h00000004;
  localparam logic [4:0] FETCH_BYTES = 5'h10;
  // flag byte bit positions
  localparam int FLG_CARRY = 0;
  localparam int FLG_PARITY = 2;
  localparam int FLG_AUX = 4;
  localparam int FLG_ZERO = 6;
  localparam int FLG_SIGN = 7;
  // control register bit positions
  localparam int CTRL_PE = 0;
  localparam int CTRL_VM = 1;
  localparam int CTRL_CPL_LO = 2;
  localparam int CTRL_AC = 4;
  // register word index (byte address bits 4:2)
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_FLAGS = 3'h1;
  localparam logic [2:0] REG_IP = 3'h2;
  localparam logic [2:0] REG_CS_LIMIT = 3'h3;
  localparam logic [2:0] REG_DS = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  // reset values
  localparam logic [4:0] RST_CTRL = 5'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [31:0] RST_IP = 32'h00000000;
  localparam logic [31:0] RST_CS_LIMIT = 32'h0000ffff;
  localparam logic RST_DS_VALID = 1'b1;

  typedef enum logic [2:0] {ST_IDLE, ST_MOFF, ST_MSEL, ST_DESC, ST_WAIT} cbfsl_st_e;
  typedef enum logic [1:0] {K_BR, K_FLAGS_TO_HIGH_ACC, K_LAR, K_LDS} cbfsl_kind_e;
  typedef enum logic [1:0] {WB_HI8, WB_16, WB_32} cbfsl_wbsz_e;

  typedef struct packed {
    logic [7:0] op0;
    logic [7:0] op1;
    logic [31:0] disp;
    logic [1:0] disp_sz;
    logic op32;
    logic [2:0] reg_idx;
    logic src_mem;
    logic [31:0] src_val;
    logic [31:0] ea;
    logic [31:0] next_ip;
  } cbfsl_ins_s;

  typedef struct packed {logic done; logic exc; logic [7:0] vector;} cbfsl_cmp_s;
  typedef struct packed {
    logic valid;
    logic [2:0] idx;
    cbfsl_wbsz_e size;
    logic [31:0] data;
  } cbfsl_wb_s;
  typedef struct packed {logic valid; logic [31:0] addr; logic [4:0] bytes;} cbfsl_fetch_s;
  typedef struct packed {logic gp; logic ss; logic pf;} cbfsl_mflt_s;

  typedef struct packed {
    cbfsl_st_e st;
    cbfsl_kind_e kind;
    logic [3:0] cnt;
    cbfsl_ins_s ins;
    logic pend;
    logic [7:0] pvec;
    logic zok;
    logic [31:0] off;
    logic [15:0] sel;
    logic [31:0] target;
    logic [4:0] ctrl;
    logic [7:0] flags;
    logic [31:0] ip;
    logic [31:0] cs_limit;
    logic [15:0] ds_sel;
    logic ds_valid;
    logic [7:0] last_vec;
    logic bus_ack;
    logic [31:0] rdata;
    cbfsl_cmp_s cmp;
    cbfsl_wb_s wb;
    cbfsl_fetch_s fetch;
    logic [31:0] mem_addr;
    logic mem_sz32;
  } cbfsl_state_s;
endpackage

//--- hw/cbfsl_exec.sv
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module cbfsl_exec (
  input logic mclk,
  input logic rst,
  input logic [4:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [3:0] avs_byteenable,
  input logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input logic ins_valid,
  input cbfsl_pkg::cbfsl_ins_s ins,
  output logic ins_ready,
  output cbfsl_pkg::cbfsl_cmp_s cmp,
  output cbfsl_pkg::cbfsl_wb_s wb,
  output cbfsl_pkg::cbfsl_fetch_s fetch,
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic mem_size32,
  input logic mem_ack,
  input logic [31:0] mem_rdata,
  input cbfsl_pkg::cbfsl_mflt_s mem_flt,
  output logic desc_req,
  output logic [15:0] desc_sel,
  input logic desc_ack,
  input logic [31:0] desc_hi,
  input logic desc_in_limit,
  input logic ds_ref_valid,
  output logic ds_ref_grant,
  output logic ds_ref_fault
);
  import cbfsl_pkg::*;

  cbfsl_state_s s;
  cbfsl_state_s n;
  logic prot;
  logic accept;
  logic two;
  logic is_br;
  logic is_flags_to_high_acc;
  logic is_lar;
  logic is_lds;
  logic cond;
  logic [3:0] ccode;
  logic [31:0] dext;
  logic [31:0] tgt;
  logic [1:0] current_privilege;
  logic [1:0] requestor_privilege;
  logic [1:0] eff_priv;
  logic [1:0] descriptor_privilege;
  logic [3:0] dtyp;
  logic dseg;
  logic conf;
  logic visible;
  logic type_ok;
  logic lds_type_ok;
  logic lds_priv_bad;
  logic sel_null;
  logic misalign;
  logic mflt;
  logic [7:0] mvec;
  logic wr_flags;
  logic lar_fin;
  logic [31:0] bus_wd;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign prot = s.ctrl[CTRL_PE] && !s.ctrl[CTRL_VM];
  assign current_privilege = s.ctrl[CTRL_CPL_LO +: 2];
  assign ins_ready = (s.st == ST_IDLE);
  assign accept = ins_valid && ins_ready;

  // instruction decode
  always_comb begin
    two = (ins.op0 == OP_TWO_BYTE);
    ccode = two ? ins.op1[3:0] : ins.op0[3:0];
    is_br = two ? (ins.op1 == OP_BRANCH_PARITY_ODD_N || ins.op1 == OP_BRANCH_ON_NEGATIVE_N ||
                   ins.op1 == OP_BRANCH_ON_ZERO_N)
                : (ins.op0 == OP_BRANCH_PARITY_ODD_S || ins.op0 == OP_BRANCH_ON_NEGATIVE_S ||
                   ins.op0 == OP_BRANCH_ON_ZERO_S);
    is_flags_to_high_acc = (ins.op0 == OP_FLAGS_TO_HIGH_ACC);
    is_lar = two && (ins.op1 == OP_ACCESS_RIGHTS_LOAD);
    is_lds = (ins.op0 == OP_FAR_POINTER_DATA_SEG_LOAD);
    unique case (ccode)
      CC_PARITY_ODD: cond = !s.flags[FLG_PARITY];
      CC_NEGATIVE: cond = s.flags[FLG_SIGN];
      CC_ZERO: cond = s.flags[FLG_ZERO];
      default: cond = 1'b0;
    endcase
    unique case (ins.disp_sz)
      2'h0: dext = {{24{ins.disp[7]}}, ins.disp[7:0]};
      2'h1: dext = {{16{ins.disp[15]}}, ins.disp[15:0]};
      default: dext = ins.disp;
    endcase
    tgt = ins.next_ip + dext;
    if (!ins.op32) begin
      tgt = tgt & IP16_MASK;
    end
  end

  // descriptor and memory checks
  always_comb begin
    requestor_privilege = s.sel[1:0];
    eff_priv = (requestor_privilege > current_privilege) ? requestor_privilege : current_privilege;
    descriptor_privilege = desc_hi[14:13];
    dseg = desc_hi[12];
    dtyp = desc_hi[11:8];
    sel_null = (s.sel[15:2] == 14'h0);
    conf = dseg && dtyp[3] && dtyp[2];
    visible = conf || (eff_priv <= descriptor_privilege);
    type_ok = dseg || LAR_SYS_VALID[dtyp];
    lds_type_ok = dseg && (!dtyp[3] || dtyp[1]);
    lds_priv_bad = !conf && ((requestor_privilege > descriptor_privilege) || (current_privilege > descriptor_privilege));
    misalign = s.mem_sz32 ? (s.mem_addr[1:0] != 2'h0) : s.mem_addr[0];
    mflt = 1'b1;
    if (mem_flt.gp) begin
      mvec = VEC_GP;
    end else if (mem_flt.ss) begin
      mvec = VEC_SS;
    end else if (mem_flt.pf) begin
      mvec = VEC_PF;
    end else if (misalign && (current_privilege == 2'h3) && s.ctrl[CTRL_AC]) begin
      mvec = VEC_AC;
    end else begin
      mvec = 8'h00;
      mflt = 1'b0;
    end
  end

  always_comb begin
    n = s;
    n.cmp = '0;
    n.wb.valid = 1'b0;
    n.fetch.valid = 1'b0;
    wr_flags = 1'b0;
    lar_fin = 1'b0;
    // register slave: one wait cycle, then the access completes
    bus_wd = 32'h0;
    n.bus_ack = (avs_read || avs_write) && !s.bus_ack;
    if ((avs_read || avs_write) && !s.bus_ack) begin
      unique case (avs_address[4:2])
        REG_CTRL: n.rdata = {27'h0, s.ctrl};
        REG_FLAGS: n.rdata = {24'h0, s.flags};
        REG_IP: n.rdata = s.ip;
        REG_CS_LIMIT: n.rdata = s.cs_limit;
        REG_DS: n.rdata = {15'h0, s.ds_valid, s.ds_sel};
        REG_STATUS: n.rdata = {23'h0, (s.st != ST_IDLE), s.last_vec};
        default: n.rdata = 32'h0;
      endcase
    end
    if (avs_write && s.bus_ack) begin
      unique case (avs_address[4:2])
        REG_CTRL: begin
          bus_wd = be_merge({27'h0, s.ctrl}, avs_writedata, avs_byteenable);
          n.ctrl = bus_wd[4:0];
        end
        REG_FLAGS: begin
          bus_wd = be_merge({24'h0, s.flags}, avs_writedata, avs_byteenable);
          n.flags = bus_wd[7:0];
          wr_flags = 1'b1;
        end
        REG_IP: n.ip = be_merge(s.ip, avs_writedata, avs_byteenable);
        REG_CS_LIMIT: n.cs_limit = be_merge(s.cs_limit, avs_writedata, avs_byteenable);
        default: bus_wd = 32'h0;
      endcase
    end
    if (s.st != ST_IDLE && s.cnt > 4'h1) begin
      n.cnt = s.cnt - 4'h1;
    end
    unique case (s.st)
      ST_IDLE: begin
        if (accept) begin
          n.ins = ins;
          n.pend = 1'b0;
          n.zok = 1'b0;
          n.st = ST_WAIT;
          if (is_br) begin
            n.kind = K_BR;
            n.target = tgt;
            if (!cond) begin
              n.ip = ins.next_ip;
              n.cmp.done = 1'b1;
              n.st = ST_IDLE;
            end else begin
              n.pend = prot && (tgt > s.cs_limit);
              n.pvec = VEC_GP;
              n.cnt = CLK_BR_TRUE - CLK_BR_FALSE;
            end
          end else if (is_flags_to_high_acc) begin
            n.kind = K_FLAGS_TO_HIGH_ACC;
            n.cnt = CLK_FLAGS_TO_HIGH_ACC - 4'h1;
          end else if (is_lar && prot) begin
            n.kind = K_LAR;
            n.cnt = CLK_ACCESS_RIGHTS - 4'h1;
            if (ins.src_mem) begin
              n.mem_addr = ins.ea;
              n.mem_sz32 = 1'b0;
              n.st = ST_MOFF;
            end else begin
              n.sel = ins.src_val[15:0];
              n.st = ST_DESC;
            end
          end else if (is_lds && ins.src_mem) begin
            n.kind = K_LDS;
            n.cnt = (prot ? CLK_LDS_PROT : CLK_LDS_REAL) - 4'h1;
            n.mem_addr = ins.ea;
            n.mem_sz32 = ins.op32;
            n.st = ST_MOFF;
          end else begin
            n.cmp = '{done: 1'b1, exc: 1'b1, vector: VEC_UD};
            n.last_vec = VEC_UD;
            n.st = ST_IDLE;
          end
        end
      end
      ST_MOFF: begin
        if (mem_ack) begin
          if (mflt) begin
            n.pend = 1'b1;
            n.pvec = mvec;
            n.st = ST_WAIT;
          end else if (s.kind == K_LAR) begin
            n.sel = mem_rdata[15:0];
            n.st = ST_DESC;
          end else begin
            n.off = s.ins.op32 ? mem_rdata : {16'h0, mem_rdata[15:0]};
            n.mem_addr = s.ins.ea + (s.ins.op32 ? SEL_OFS32 : SEL_OFS16);
            n.mem_sz32 = 1'b0;
            n.st = ST_MSEL;
          end
        end
      end
      ST_MSEL: begin
        if (mem_ack) begin
          if (mflt) begin
            n.pend = 1'b1;
            n.pvec = mvec;
            n.st = ST_WAIT;
          end else begin
            n.sel = mem_rdata[15:0];
            n.st = (prot && (mem_rdata[15:2] != 14'h0)) ? ST_DESC : ST_WAIT;
          end
        end
      end
      ST_DESC: begin
        if (desc_ack) begin
          n.st = ST_WAIT;
          if (s.kind == K_LAR) begin
            n.zok = desc_in_limit && !sel_null && visible && type_ok;
            n.off = desc_hi & LAR_MASK;
          end else if (!desc_in_limit || !lds_type_ok || lds_priv_bad) begin
            n.pend = 1'b1;
            n.pvec = VEC_GP;
          end else if (!desc_hi[15]) begin
            n.pend = 1'b1;
            n.pvec = VEC_NP;
          end
        end
      end
      ST_WAIT: begin
        if (s.cnt <= 4'h1) begin
          n.st = ST_IDLE;
          n.cmp.done = 1'b1;
          if (s.pend) begin
            n.cmp.exc = 1'b1;
            n.cmp.vector = s.pvec;
            n.last_vec = s.pvec;
          end else begin
            n.ip = s.ins.next_ip;
            unique case (s.kind)
              K_BR: begin
                n.ip = s.target;
                n.fetch = '{valid: 1'b1, addr: s.target, bytes: FETCH_BYTES};
              end
              K_FLAGS_TO_HIGH_ACC: begin
                n.wb = '{valid: 1'b1, idx: 3'h0, size: WB_HI8, data: {24'h0, s.flags}};
              end
              K_LAR: begin
                lar_fin = 1'b1;
                n.flags[FLG_ZERO] = s.zok;
                n.wb.valid = s.zok;
                n.wb.idx = s.ins.reg_idx;
                n.wb.size = s.ins.op32 ? WB_32 : WB_16;
                n.wb.data = s.ins.op32 ? s.off : {16'h0, s.off[15:0]};
              end
              K_LDS: begin
                n.wb.valid = 1'b1;
                n.wb.idx = s.ins.reg_idx;
                n.wb.size = s.ins.op32 ? WB_32 : WB_16;
                n.wb.data = s.off;
                n.ds_sel = s.sel;
                n.ds_valid = !(prot && sel_null);
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.ctrl <= RST_CTRL;
      s.flags <= RST_FLAGS;
      s.ip <= RST_IP;
      s.cs_limit <= RST_CS_LIMIT;
      s.ds_valid <= RST_DS_VALID;
    end else begin
      s <= n;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !s.bus_ack;
  assign avs_readdata = s.rdata;
  assign cmp = s.cmp;
  assign wb = s.wb;
  assign fetch = s.fetch;
  assign mem_req = (s.st == ST_MOFF) || (s.st == ST_MSEL);
  assign mem_addr = s.mem_addr;
  assign mem_size32 = s.mem_sz32;
  assign desc_req = (s.st == ST_DESC);
  assign desc_sel = s.sel;
  assign ds_ref_grant = ds_ref_valid && s.ds_valid;
  assign ds_ref_fault = ds_ref_valid && !s.ds_valid;

  property p_br_false;
    @(posedge mclk) disable iff (rst)
      accept && is_br && !cond |=> cmp.done && !cmp.exc && s.ip == $past(ins.next_ip);
  endproperty
  a_br_false: assert property (p_br_false) else $error("false branch not done in one clock");

  property p_br_true;
    @(posedge mclk) disable iff (rst)
      accept && is_br && cond |=> !cmp.done ##1 !cmp.done ##1 cmp.done;
  endproperty
  a_br_true: assert property (p_br_true) else $error("taken branch not done in three clocks");

  property p_flags_to_high_acc;
    @(posedge mclk) disable iff (rst)
      accept && is_flags_to_high_acc |=> !cmp.done[*2] ##1 (cmp.done && !cmp.exc && wb.valid &&
                                               wb.size == WB_HI8);
  endproperty
  a_flags_to_high_acc: assert property (p_flags_to_high_acc) else $error("flag byte move timing or result wrong");

  property p_fetch16;
    @(posedge mclk) disable iff (rst)
      fetch.valid |-> cmp.done && fetch.bytes == FETCH_BYTES && s.ip == fetch.addr;
  endproperty
  a_fetch16: assert property (p_fetch16) else $error("taken branch fetch not 16 bytes");

  property p_ip_mask;
    @(posedge mclk) disable iff (rst)
      fetch.valid && !s.ins.op32 |-> fetch.addr[31:16] == 16'h0;
  endproperty
  a_ip_mask: assert property (p_ip_mask) else $error("16-bit branch target not masked");

  property p_lar_ud;
    @(posedge mclk) disable iff (rst)
      accept && is_lar && !prot |=> cmp.done && cmp.exc && cmp.vector == VEC_UD;
  endproperty
  a_lar_ud: assert property (p_lar_ud) else $error("access-rights load not refused");

  property p_zf_source;
    @(posedge mclk) disable iff (rst)
      s.flags != $past(s.flags) |-> $past(wr_flags) || $past(lar_fin);
  endproperty
  a_zf_source: assert property (p_zf_source) else $error("flags changed unexpectedly");

  property p_ds_null;
    @(posedge mclk) disable iff (rst)
      ds_ref_valid && !s.ds_valid |-> ds_ref_fault && !ds_ref_grant;
  endproperty
  a_ds_null: assert property (p_ds_null) else $error("null data segment access granted");

  property p_sel_addr;
    @(posedge mclk) disable iff (rst)
      s.st == ST_MSEL |-> s.mem_addr == s.ins.ea + (s.ins.op32 ? SEL_OFS32 : SEL_OFS16);
  endproperty
  a_sel_addr: assert property (p_sel_addr) else $error("selector address offset wrong");
endmodule

//--- tb/cbfsl_partner.sv
`timescale 1ns/1ps
module cbfsl_partner (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] lat,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  input wire logic desc_req,
  output logic desc_ack,
  input wire logic [31:0] dhi,
  output logic [31:0] desc_hi
);
  logic [3:0] mw, dw;
  logic [31:0] lm, ld;
  // answer after lat waiting cycles; between answers the data lines toggle
  assign mem_ack = mem_req && mw == lat;
  assign desc_ack = desc_req && dw == lat;
  assign mem_rdata = mem_ack ? {~mem_addr[15:0], mem_addr[15:0] ^ 16'h3c3c} : ~lm;
  assign desc_hi = desc_ack ? dhi : ~ld;
  always_ff @(posedge mclk) begin
    mw <= (rst || !mem_req || mem_ack) ? 4'h0 : mw + 4'h1;
    dw <= (rst || !desc_req || desc_ack) ? 4'h0 : dw + 4'h1;
    lm <= rst ? 32'h0 : mem_rdata;
    ld <= rst ? 32'h0 : desc_hi;
  end
endmodule

//--- tb/cbfsl_exec_tb.sv
`timescale 1ns/1ps
module cbfsl_exec_tb;
  import cbfsl_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0;
  logic ins_valid = 1'b0;
  cbfsl_ins_s ins = '0;
  cbfsl_mflt_s mem_flt = '0;
  logic [31:0] dhi = 32'h0;
  logic [3:0] lat = 4'h0;
  logic desc_in_limit = 1'b1;
  logic ds_ref_valid = 1'b1;
  logic [31:0] avs_readdata, mem_addr, mem_rdata, desc_hi, rd;
  logic avs_waitrequest, ins_ready, mem_req, mem_size32, mem_ack, desc_req, desc_ack;
  logic ds_ref_grant, ds_ref_fault;
  logic [15:0] desc_sel;
  cbfsl_cmp_s cmp, g_cmp;
  cbfsl_wb_s wb, g_wb;
  cbfsl_fetch_s fetch, g_fetch;
  int n_errors = 0;
  int n_checks = 0;
  int n_got;
  always #10 mclk = ~mclk;
  cbfsl_exec i_cbfsl_exec (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .ins_valid, .ins, .ins_ready, .cmp, .wb,
    .fetch, .mem_req, .mem_addr, .mem_size32, .mem_ack, .mem_rdata, .mem_flt, .desc_req,
    .desc_sel, .desc_ack, .desc_hi, .desc_in_limit, .ds_ref_valid, .ds_ref_grant, .ds_ref_fault);
  cbfsl_partner i_cbfsl_partner (.mclk, .rst, .lat, .mem_req, .mem_addr, .mem_ack, .mem_rdata,
    .desc_req, .desc_ack, .dhi, .desc_hi);
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic run(input cbfsl_ins_s x);
    @(posedge mclk);
    ins <= x;
    ins_valid <= 1'b1;
    do @(negedge mclk); while (ins_ready !== 1'b1);
    @(posedge mclk);
    ins_valid <= 1'b0;
    n_got = 0;
    do begin
      @(negedge mclk);
      n_got++;
    end while (cmp.done !== 1'b1 && n_got < 200);
    g_cmp = cmp;
    g_wb = wb;
    g_fetch = fetch;
  endtask
  function automatic logic [31:0] mv(input logic [31:0] a);
    return {~a[15:0], a[15:0] ^ 16'h3c3c};
  endfunction
  function automatic logic [31:0] tgt(input cbfsl_ins_s x);
    logic [31:0] d;
    d = x.disp_sz == 2'h0 ? {{24{x.disp[7]}}, x.disp[7:0]} :
        x.disp_sz == 2'h1 ? {{16{x.disp[15]}}, x.disp[15:0]} : x.disp;
    d = x.next_ip + d;
    return x.op32 ? d : d & 32'h0000ffff;
  endfunction
  task automatic t_reset();
    logic [31:0] ev [7] = '{32'h0, 32'h0, 32'h0, 32'h0000ffff, 32'h00010000, 32'h0, 32'h0};
    bus(1'b1, 5'h10, 32'hffffffff);
    bus(1'b1, 5'h18, 32'hffffffff);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 5'(i * 4), 32'h0);
      chk("register", rd, ev[i]);
    end
    $display("test reset done");
  endtask
  task automatic t_branch();
    cbfsl_ins_s x;
    logic [7:0] f;
    logic [31:0] ip0;
    logic tk;
    for (int i = 0; i < 32; i++) begin
      f = 8'($urandom);
      x = '0;
      x.op1 = i % 3 == 0 ? OP_BRANCH_PARITY_ODD_N :
              i % 3 == 1 ? OP_BRANCH_ON_NEGATIVE_N : OP_BRANCH_ON_ZERO_N;
      x.op0 = i % 2 ? OP_TWO_BYTE : {4'h7, x.op1[3:0]};
      x.op32 = 1'($urandom);
      x.disp_sz = i % 2 ? {x.op32, !x.op32} : 2'h0;
      x.disp = $urandom;
      x.next_ip = x.op32 ? $urandom : $urandom & 32'hffff;
      tk = i % 3 == 0 ? !f[2] : i % 3 == 1 ? f[7] : f[6];
      if (i >= 30) begin
        bus(1'b1, 5'h00, 32'h1);
        bus(1'b1, 5'h0c, 32'h100);
        f = 8'h40;
        tk = 1'b1;
        x.op0 = OP_TWO_BYTE;
        x.op1 = OP_BRANCH_ON_ZERO_N;
        {x.op32, x.disp_sz, x.next_ip, x.disp} = {3'h6, 32'h80, 32'h80 + 32'(i - 30)};
      end
      bus(1'b1, 5'h04, {24'h0, f});
      bus(1'b0, 5'h08, 32'h0);
      ip0 = rd;
      run(x);
      chk("cycles", n_got, tk ? 3 : 1);
      chk("fault", {g_cmp.exc, g_wb.valid}, {i == 31, 1'b0});
      if (i == 31) chk("vector", g_cmp.vector, VEC_GP);
      chk("fetch", g_fetch.valid, tk && i != 31);
      if (tk && i != 31) chk("fetch", {g_fetch.addr, g_fetch.bytes}, {tgt(x), 5'h10});
      bus(1'b0, 5'h08, 32'h0);
      chk("ip", rd, i == 31 ? ip0 : tk ? tgt(x) : x.next_ip);
      bus(1'b0, 5'h04, 32'h0);
      chk("flags", rd[7:0], f);
    end
    $display("test branch done");
  endtask
  task automatic t_flags_to_high_acc();
    cbfsl_ins_s x;
    logic [7:0] f;
    for (int i = 0; i < 3; i++) begin
      f = 8'($urandom);
      bus(1'b1, 5'h00, i == 2 ? 32'h3 : 32'(i));
      bus(1'b1, 5'h04, {24'h0, f});
      x = '0;
      x.op0 = OP_FLAGS_TO_HIGH_ACC;
      run(x);
      chk("cycles", {n_got[3:0], g_cmp.exc}, {4'h3, 1'b0});
      chk("high byte", {g_wb.valid, g_wb.size, g_wb.data[7:0] & 8'hd5},
          {1'b1, WB_HI8, f & 8'hd5});
      bus(1'b0, 5'h04, 32'h0);
      chk("flags", rd[7:0], f);
    end
    $display("test flag byte done");
  endtask
  task automatic t_lar();
    cbfsl_ins_s x;
    logic [31:0] h, m, k;
    logic [7:0] f;
    logic [4:0] c;
    logic ok, lim;
    for (int i = 0; i < 35; i++) begin
      c = i == 33 ? 5'h0 : i == 34 ? 5'h3 : 5'h1;
      x = '0;
      x.op0 = OP_TWO_BYTE;
      x.op1 = OP_ACCESS_RIGHTS_LOAD;
      x.op32 = 1'($urandom);
      x.src_mem = 1'($urandom);
      x.reg_idx = 3'($urandom);
      x.src_val = ($urandom & 32'hfff8) | 32'h8;
      x.ea = $urandom & 32'hfffc;
      h = $urandom;
      h[12:8] = 5'(i);
      if (i == 32) begin
        x.src_val[1:0] = 2'h3;
        x.src_mem = 1'b0;
        h = 32'h00409200;
      end
      m = x.src_mem ? mv(x.ea) : x.src_val;
      lim = ($urandom & 7) != 0;
      ok = (h[12] || !(h[11:8] inside {4'h0, 4'h8, 4'ha, 4'hd})) && lim && m[15:2] != 0 && i < 32;
      k = x.op32 ? 32'h00f0ff00 : 32'h0000ff00;
      f = 8'($urandom);
      bus(1'b1, 5'h00, {27'h0, c});
      bus(1'b1, 5'h04, {24'h0, f});
      dhi <= h;
      desc_in_limit <= lim;
      run(x);
      if (c != 5'h1) chk("fault", {g_cmp.exc, g_cmp.vector, n_got[3:0]}, {1'b1, VEC_UD, 4'h1});
      else begin
        chk("cycles", {n_got[3:0], g_cmp.exc, g_wb.valid}, {4'hb, 1'b0, ok});
        if (ok) chk("result", {g_wb.idx, g_wb.size, g_wb.data & k},
            {x.reg_idx, x.op32 ? WB_32 : WB_16, h & k});
        bus(1'b0, 5'h04, 32'h0);
        chk("flags", rd[7:0], {f[7], ok, f[5:0]});
      end
    end
    desc_in_limit <= 1'b1;
    $display("test access rights done");
  endtask
  task automatic far_pointer_data_seg_load(input logic [4:0] c, input logic o, input logic [31:0] ea,
                     input logic [31:0] h, input logic lim, input logic [2:0] fl,
                     input logic [7:0] v, input int n);
    cbfsl_ins_s x;
    logic [31:0] m, ds0, k;
    logic ok;
    bus(1'b1, 5'h00, {27'h0, c});
    bus(1'b0, 5'h10, 32'h0);
    ds0 = rd;
    dhi <= h;
    desc_in_limit <= lim;
    mem_flt <= fl;
    x = '0;
    x.op0 = OP_FAR_POINTER_DATA_SEG_LOAD;
    x.op32 = o;
    x.src_mem = v != VEC_UD;
    x.ea = ea;
    x.reg_idx = 3'($urandom);
    run(x);
    m = mv(ea + (o ? 32'h4 : 32'h2));
    ok = !c[0] || m[15:2] != 14'h0;
    k = o ? 32'hffffffff : 32'h0000ffff;
    if (n > 0) chk("cycles", n_got, n);
    chk("fault", {g_cmp.exc, g_wb.valid}, {v != 8'h0, v == 8'h0});
    if (v != 8'h0) chk("vector", g_cmp.vector, v);
    else chk("offset", {g_wb.size, g_wb.idx, g_wb.data & k},
        {o ? WB_32 : WB_16, x.reg_idx, mv(ea) & k});
    bus(1'b0, 5'h10, 32'h0);
    chk("data segment", rd, v != 8'h0 ? ds0 : {15'h0, ok, m[15:0]});
    ok = v != 8'h0 ? ds0[16] : ok;
    chk("reference", {ds_ref_grant, ds_ref_fault}, {ok, !ok});
    mem_flt <= '0;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    $display("watchdog expired");
    complete_run();
  end
  initial begin
    void'($urandom(32'h62933834));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_branch();
    t_flags_to_high_acc();
    t_lar();
    far_pointer_data_seg_load(5'h00, 1'b1, 32'h1000, 32'h0, 1'b1, 3'h0, 8'h0, 6);
    far_pointer_data_seg_load(5'h00, 1'b0, 32'h2002, 32'h0, 1'b1, 3'h0, 8'h0, 6);
    far_pointer_data_seg_load(5'h01, 1'b1, 32'h3000, 32'h0000f200, 1'b1, 3'h0, 8'h0, 12);
    far_pointer_data_seg_load(5'h01, 1'b0, 32'h3c3a, 32'h0000f200, 1'b1, 3'h0, 8'h0, 0);
    far_pointer_data_seg_load(5'h01, 1'b0, 32'h4000, 32'h0000f200, 1'b0, 3'h0, VEC_GP, 0);
    far_pointer_data_seg_load(5'h01, 1'b1, 32'h4000, 32'h0000f800, 1'b1, 3'h0, VEC_GP, 0);
    far_pointer_data_seg_load(5'h0d, 1'b1, 32'h4000, 32'h00009200, 1'b1, 3'h0, VEC_GP, 0);
    far_pointer_data_seg_load(5'h01, 1'b1, 32'h4000, 32'h00007200, 1'b1, 3'h0, VEC_NP, 0);
    far_pointer_data_seg_load(5'h01, 1'b1, 32'h4000, 32'h0000f200, 1'b1, 3'h4, VEC_GP, 0);
    far_pointer_data_seg_load(5'h01, 1'b1, 32'h4000, 32'h0000f200, 1'b1, 3'h2, VEC_SS, 0);
    far_pointer_data_seg_load(5'h01, 1'b1, 32'h4000, 32'h0000f200, 1'b1, 3'h1, VEC_PF, 0);
    far_pointer_data_seg_load(5'h1d, 1'b1, 32'h4002, 32'h0000f200, 1'b1, 3'h0, VEC_AC, 0);
    far_pointer_data_seg_load(5'h01, 1'b1, 32'h4000, 32'h0000f200, 1'b1, 3'h0, VEC_UD, 1);
    lat <= 4'h3;
    far_pointer_data_seg_load(5'h01, 1'b0, 32'h5000, 32'h0000f200, 1'b1, 3'h0, 8'h0, 0);
    lat <= 4'h0;
    $display("test pointer load done");
    complete_run();
  end
endmodule
